// >>> verilog/upe_pkg.sv
// Package with the register map, field layout and input carriers of the protocol event register.
package upe_pkg;

  localparam int          NUM_EVENTS = 16;
  localparam int          BUS_W      = 32;
  localparam int          DEV_ADDR_W = 7;
  localparam int          SPEED_W    = 7;
  localparam int          NUM_HP_W   = 8;
  localparam int          DIR_W      = 2;
  localparam int          LMP_W      = 32;

  localparam logic [31:0] PROTOCOL_EVENT_CAUSES_ADDR  = 32'he0033404;
  localparam logic [31:0] PROTOCOL_EVENT_ENABLES_ADDR = 32'he0033408;
  localparam logic [31:0] PROTOCOL_EVENT_FORCE_ADDR   = 32'he00334f0;
  localparam logic [31:0] PROTOCOL_STATE_ADDR         = 32'he00334f4;
  localparam logic [31:0] LINK_PACKET_BUFFER_ADDR     = 32'he00334f8;

  localparam logic [15:0] EVENT_RESET   = 16'h0000;
  localparam logic [15:0] ENABLE_RESET  = 16'h0000;
  localparam logic [6:0]  DEV_ADDR_RESET = 7'h00;

  localparam int BIT_ZERO_ADDRESS     = 15;
  localparam int BIT_EP0_STALL        = 14;
  localparam int BIT_BAD_PORT_CFG     = 13;
  localparam int BIT_BAD_PORT_CAP     = 12;
  localparam int BIT_STATUS_STAGE     = 11;
  localparam int BIT_HOST_ERROR       = 10;
  localparam int BIT_SETUP_RECEIVED   = 9;
  localparam int BIT_TIMESTAMP        = 8;
  localparam int BIT_HOST_ACK_TIMER   = 7;
  localparam int BIT_PING_TIMER       = 6;
  localparam int BIT_PORT_CFG_TIMER   = 5;
  localparam int BIT_PORT_CAP_TIMER   = 4;
  localparam int BIT_PORT_CFG_RX      = 3;
  localparam int BIT_PORT_CAP_RX      = 2;
  localparam int BIT_UNKNOWN_LMP      = 1;
  localparam int BIT_LMP_RX           = 0;

  localparam int BIT_STATE_STALL      = 7;

  localparam logic [SPEED_W-1:0]  GOOD_LINK_SPEED = 7'h01;
  localparam logic [NUM_HP_W-1:0] GOOD_NUM_HP     = 8'h04;

  typedef enum logic [1:0] {
    UPE_LMP_PORT_CFG,
    UPE_LMP_PORT_CAP,
    UPE_LMP_OTHER
  } upe_lmp_kind_t;

  typedef struct packed {
    logic                  setup_seen;
    logic                  setup_good;
    logic                  setup_is_set_addr;
    logic [DEV_ADDR_W-1:0] setup_addr;
    logic                  ingress_overrun;
    logic                  egress_overrun;
    logic                  status_data_moved;
    logic                  status_done;
    logic                  ack_tp_seen;
    logic                  ack_host_error;
    logic                  timestamp_seen;
  } upe_packet_ev_t;

  typedef struct packed {
    logic host_ack;
    logic ping;
    logic port_cfg;
    logic port_cap;
  } upe_timer_ev_t;

  typedef struct packed {
    logic                valid;
    upe_lmp_kind_t       kind;
    logic [SPEED_W-1:0]  link_speed;
    logic [NUM_HP_W-1:0] num_hp;
    logic [DIR_W-1:0]    direction;
    logic [LMP_W-1:0]    payload;
  } upe_lmp_t;

endpackage : upe_pkg

// >>> verilog/upe_protocol_event_register.sv
// Protocol layer event cause register with enables, forcing path and interrupt request.
//
// Notes on behaviour
// - A set-address request that assigns address zero raises the zero-address event.
// - Ingress overrun, egress overrun or status-stage data stall endpoint zero and flag it.
// - Only a valid SETUP ends the endpoint-zero stall; one that is not a set-address also raises setup-received.
// - A port configuration packet with link speed not one flags a bad configuration.
// - Port capability with speed not one, buffers not four or direction bit zero clear.
// - Finishing the status stage of a control transfer raises the status-stage event.
// - An acknowledge packet carrying the host error bit raises the host-error event.
// - Every SETUP, valid or not, except a set-address, raises setup-received.
// - Set-address SETUPs are handled fully here, storing the address without firmware.
// - Each isochronous timestamp packet raises the timestamp event.
// - Expiry of the host acknowledge response timer raises its event.
// - Expiry of the ping timer raises its event.
// - Expiry of the port configuration timer raises its event.
// - Expiry of the port capabilities timer raises its event.
// - A port configuration packet raises its received event; a reply may follow.
// - A port capabilities packet raises its received event; a reply may follow.
// - An unknown link packet is stored, gets no reply, and raises its event.
// - Every link packet is stored and raises the link-packet-received event.
// - A latched event raises the interrupt only while its enable bit is one; the causes register reads it regardless.

`timescale 1ns/1ns
`default_nettype none

module upe_protocol_event_register #(
  parameter int EVENT_COUNT = 16
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic [31:0]                  i_addr,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output var  logic [31:0]                  o_rdata,
  input  wire upe_pkg::upe_packet_ev_t      i_packet,
  input  wire upe_pkg::upe_timer_ev_t       i_timer,
  input  wire upe_pkg::upe_lmp_t            i_lmp,
  input  wire logic                         i_auto_reply_cfg,
  input  wire logic                         i_auto_reply_cap,
  output var  logic                         o_ep0_stall,
  output var  logic [upe_pkg::DEV_ADDR_W-1:0] o_device_address,
  output var  logic [upe_pkg::LMP_W-1:0]    o_lmp_buffer,
  output var  logic                         o_lmp_reply_cfg,
  output var  logic                         o_lmp_reply_cap,
  output var  logic                         o_irq
);

  import upe_pkg::*;

  // Parameter values that the fixed sixteen-bit map cannot serve are refused.
  if (EVENT_COUNT != NUM_EVENTS) begin : g_bad_count
    $error("EVENT_COUNT must equal the sixteen event causes");
  end

  if (BIT_STATE_STALL != DEV_ADDR_W) begin : g_bad_state_layout
    $error("The stall bit must sit just above the device address");
  end

  // Register storage.
  wire logic [15:0]      events_q;
  logic [15:0]           enables_q;
  logic [15:0]           enables_d;
  logic                  stall_q;
  logic                  stall_d;
  logic [DEV_ADDR_W-1:0] dev_addr_q;
  logic [DEV_ADDR_W-1:0] dev_addr_d;
  logic [LMP_W-1:0]      lmp_buf_q;
  logic [LMP_W-1:0]      lmp_buf_d;
  logic                  reply_cfg_q;
  logic                  reply_cap_q;
  logic                  irq_q;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;

  // Bus decode.
  // Addresses are compared in full, so aliases of the map read as zero.
  wire logic hit_causes;
  wire logic hit_enables;
  wire logic hit_force;
  wire logic hit_state;
  wire logic hit_lmp;
  wire logic wr_causes;
  wire logic wr_enables;
  wire logic wr_force;
  wire logic [15:0] clear_mask;
  wire logic [15:0] force_mask;

  assign hit_causes  = (i_addr == PROTOCOL_EVENT_CAUSES_ADDR);
  assign hit_enables = (i_addr == PROTOCOL_EVENT_ENABLES_ADDR);
  assign hit_force   = (i_addr == PROTOCOL_EVENT_FORCE_ADDR);
  assign hit_state   = (i_addr == PROTOCOL_STATE_ADDR);
  assign hit_lmp     = (i_addr == LINK_PACKET_BUFFER_ADDR);
  assign wr_causes   = i_wr & hit_causes;
  assign wr_enables  = i_wr & hit_enables;
  assign wr_force    = i_wr & hit_force;
  assign clear_mask  = wr_causes ? i_wdata[15:0] : 16'h0000;
  assign force_mask  = wr_force ? i_wdata[15:0] : 16'h0000;

  // SETUP classification.
  // An invalid set-address still ends no stall and never raises setup-received.
  wire logic setup_set_addr;
  wire logic setup_other;
  wire logic setup_good_set_addr;
  wire logic zero_address_assigned_event;

  assign setup_set_addr      = i_packet.setup_seen & i_packet.setup_is_set_addr;
  assign setup_other         = i_packet.setup_seen & ~i_packet.setup_is_set_addr;
  assign setup_good_set_addr = setup_set_addr & i_packet.setup_good;
  assign zero_address_assigned_event =
    setup_good_set_addr & (i_packet.setup_addr == DEV_ADDR_RESET);

  // Endpoint-zero stall.
  // The stall is a level that only a valid SETUP ends.
  wire logic control_endpoint_stall_event;
  wire logic stall_release;

  assign control_endpoint_stall_event = i_packet.ingress_overrun
                                      | i_packet.egress_overrun
                                      | i_packet.status_data_moved;
  assign stall_release = i_packet.setup_seen & i_packet.setup_good;

  // A fresh stall cause wins over a SETUP arriving in the same cycle.
  assign stall_d = control_endpoint_stall_event ? 1'b1 :
                   stall_release                ? 1'b0 : stall_q;

  // Set-address is taken into the device address register by hardware alone.
  assign dev_addr_d = setup_good_set_addr ? i_packet.setup_addr : dev_addr_q;

  // Link management packets.
  // Code three of the kind field is treated as unknown as well.
  wire logic lmp_is_cfg;
  wire logic lmp_is_cap;
  wire logic lmp_is_unknown;
  wire logic bad_port_configuration_event;
  wire logic bad_port_capability_event;
  wire logic port_configuration_received;
  wire logic port_capability_received;
  wire logic unrecognised_link_packet_event;
  wire logic link_packet_received_event;

  assign lmp_is_cfg     = i_lmp.valid & (i_lmp.kind == UPE_LMP_PORT_CFG);
  assign lmp_is_cap     = i_lmp.valid & (i_lmp.kind == UPE_LMP_PORT_CAP);
  assign lmp_is_unknown = i_lmp.valid & ~lmp_is_cfg & ~lmp_is_cap;

  assign bad_port_configuration_event =
    lmp_is_cfg & (i_lmp.link_speed != GOOD_LINK_SPEED);
  assign bad_port_capability_event =
    lmp_is_cap & ((i_lmp.link_speed != GOOD_LINK_SPEED)
               | (i_lmp.num_hp != GOOD_NUM_HP)
               | ~i_lmp.direction[0]);
  assign port_configuration_received    = lmp_is_cfg;
  assign port_capability_received       = lmp_is_cap;
  assign unrecognised_link_packet_event = lmp_is_unknown;
  assign link_packet_received_event     = i_lmp.valid;

  // Every arriving packet overwrites the buffer, known or not.
  assign lmp_buf_d = i_lmp.valid ? i_lmp.payload : lmp_buf_q;

  // Hardware event vector.
  // Bit positions come from the package so the map lives in one place.
  wire logic [15:0] hw_set;

  assign hw_set[BIT_ZERO_ADDRESS]   = zero_address_assigned_event;
  assign hw_set[BIT_EP0_STALL]      = control_endpoint_stall_event;
  assign hw_set[BIT_BAD_PORT_CFG]   = bad_port_configuration_event;
  assign hw_set[BIT_BAD_PORT_CAP]   = bad_port_capability_event;
  assign hw_set[BIT_STATUS_STAGE]   = i_packet.status_done;
  assign hw_set[BIT_HOST_ERROR]     = i_packet.ack_tp_seen & i_packet.ack_host_error;
  assign hw_set[BIT_SETUP_RECEIVED] = setup_other;
  assign hw_set[BIT_TIMESTAMP]      = i_packet.timestamp_seen;
  assign hw_set[BIT_HOST_ACK_TIMER] = i_timer.host_ack;
  assign hw_set[BIT_PING_TIMER]     = i_timer.ping;
  assign hw_set[BIT_PORT_CFG_TIMER] = i_timer.port_cfg;
  assign hw_set[BIT_PORT_CAP_TIMER] = i_timer.port_cap;
  assign hw_set[BIT_PORT_CFG_RX]    = port_configuration_received;
  assign hw_set[BIT_PORT_CAP_RX]    = port_capability_received;
  assign hw_set[BIT_UNKNOWN_LMP]    = unrecognised_link_packet_event;
  assign hw_set[BIT_LMP_RX]         = link_packet_received_event;

  // Each cause bit is its own flag cell.
  for (genvar b = 0; b < NUM_EVENTS; b++) begin : g_flag
    upe_event_flag #(
      .RESET_VALUE(EVENT_RESET[b])
    ) u_flag (
      .i_clk  (i_clk),
      .i_rst_n(i_rst_n),
      .i_set  (hw_set[b]),
      .i_clear(clear_mask[b]),
      .i_force(force_mask[b]),
      .o_flag (events_q[b])
    );
  end

  // Only the low sixteen bits of a write to the enables are kept.
  assign enables_d = wr_enables ? i_wdata[15:0] : enables_q;

  // Reply requests only for recognised port packets with auto-reply armed.
  // A reply request lasts one cycle, the cycle after the packet.
  wire logic reply_cfg_d;
  wire logic reply_cap_d;

  assign reply_cfg_d = port_configuration_received & i_auto_reply_cfg;
  assign reply_cap_d = port_capability_received & i_auto_reply_cap;

  // Interrupt request.
  // The request comes from the flopped flags, so it lags a cause bit by one cycle.
  wire logic [15:0] pending;
  wire logic        irq_d;

  assign pending = events_q & enables_q;
  assign irq_d   = |pending;

  // Read data selection; reads return zero outside the cycle after the read strobe.
  wire logic [31:0] state_word;
  wire logic [31:0] causes_word;
  wire logic [31:0] enables_word;
  wire logic [31:0] rd_word;

  // The state word shows the stall bit above the device address.
  assign state_word   = {24'h000000, stall_q, dev_addr_q};
  assign causes_word  = {16'h0000, events_q};
  assign enables_word = {16'h0000, enables_q};
  assign rd_word      = hit_causes  ? causes_word :
                        hit_enables ? enables_word :
                        hit_state   ? state_word :
                        hit_lmp     ? lmp_buf_q : 32'h00000000;
  assign rdata_d      = i_rd ? rd_word : 32'h00000000;

  // Every register below resets asynchronously to its value after reset.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enables_q <= ENABLE_RESET;
    end else begin
      enables_q <= enables_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= stall_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dev_addr_q <= DEV_ADDR_RESET;
    end else begin
      dev_addr_q <= dev_addr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lmp_buf_q <= '0;
    end else begin
      lmp_buf_q <= lmp_buf_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reply_cfg_q <= 1'b0;
    end else begin
      reply_cfg_q <= reply_cfg_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reply_cap_q <= 1'b0;
    end else begin
      reply_cap_q <= reply_cap_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs are taken straight from their flops.
  assign o_rdata          = rdata_q;
  assign o_ep0_stall      = stall_q;
  assign o_device_address = dev_addr_q;
  assign o_lmp_buffer     = lmp_buf_q;
  assign o_lmp_reply_cfg  = reply_cfg_q;
  assign o_lmp_reply_cap  = reply_cap_q;
  assign o_irq            = irq_q;

endmodule : upe_protocol_event_register

// One event flag: hardware set and software force win over a software clear.
// It holds its value until software clears it.
module upe_event_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  input  wire logic i_force,
  output var  logic o_flag
);

  logic flag_q;
  logic flag_d;

  // The set terms are ORed after the clear so a simultaneous event survives.
  // Forcing is for test and shares the set path with hardware events.
  assign flag_d = (flag_q & ~i_clear) | i_set | i_force;

  // The flag is a plain flop with no enable.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q <= RESET_VALUE;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : upe_event_flag

`default_nettype wire

// >>> tb/upe_sva.sv
// Concurrent checks on the ports of the protocol event register.
`timescale 1ns/1ns
`default_nettype none
module upe_sva #(
  parameter int EVENT_COUNT = 16
) (
  input wire logic                           i_clk,
  input wire logic                           i_rst_n,
  input wire logic [31:0]                    i_addr,
  input wire logic [31:0]                    i_wdata,
  input wire logic                           i_wr,
  input wire upe_pkg::upe_packet_ev_t        i_packet,
  input wire upe_pkg::upe_lmp_t              i_lmp,
  input wire logic                           i_auto_reply_cfg,
  input wire logic                           i_auto_reply_cap,
  input wire logic                           o_ep0_stall,
  input wire logic [upe_pkg::DEV_ADDR_W-1:0] o_device_address,
  input wire logic [upe_pkg::LMP_W-1:0]      o_lmp_buffer,
  input wire logic                           o_lmp_reply_cfg,
  input wire logic                           o_lmp_reply_cap,
  input wire logic                           o_irq
);
  import upe_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic cause = i_packet.ingress_overrun | i_packet.egress_overrun
                     | i_packet.status_data_moved;
  wire logic good  = i_packet.setup_seen & i_packet.setup_good;
  wire logic cfg   = i_lmp.valid & (i_lmp.kind == UPE_LMP_PORT_CFG);
  wire logic cap   = i_lmp.valid & (i_lmp.kind == UPE_LMP_PORT_CAP);
  AST_STALL_SET: assert property (cause |=> o_ep0_stall)
    else $error("stall not raised");
  AST_STALL_HOLD: assert property (o_ep0_stall && !good |=> o_ep0_stall)
    else $error("stall left without valid setup");
  AST_STALL_LEAVE: assert property (o_ep0_stall && good && !i_packet.setup_is_set_addr
    && !cause |=> !o_ep0_stall) else $error("stall kept after valid setup");
  AST_ADDR: assert property (good && i_packet.setup_is_set_addr
    |=> o_device_address == $past(i_packet.setup_addr)) else $error("address not stored");
  AST_BUF: assert property (i_lmp.valid |=> o_lmp_buffer == $past(i_lmp.payload))
    else $error("link packet not stored");
  AST_UNK: assert property (i_lmp.valid && !cfg && !cap
    |=> !o_lmp_reply_cfg && !o_lmp_reply_cap) else $error("reply to unknown packet");
  AST_CFG_REPLY: assert property (cfg && i_auto_reply_cfg |=> o_lmp_reply_cfg)
    else $error("configuration reply missing");
  AST_CAP_REPLY: assert property (cap && i_auto_reply_cap |=> o_lmp_reply_cap)
    else $error("capability reply missing");
  AST_IRQ_QUIET: assert property (i_wr && i_addr == PROTOCOL_EVENT_ENABLES_ADDR
    && i_wdata[15:0] == 16'h0 |-> ##2 !o_irq) else $error("irq with all enables off");
endmodule : upe_sva
bind upe_protocol_event_register upe_sva #(.EVENT_COUNT(EVENT_COUNT)) u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_packet(i_packet), .i_lmp(i_lmp), .i_auto_reply_cfg(i_auto_reply_cfg),
  .i_auto_reply_cap(i_auto_reply_cap), .o_ep0_stall(o_ep0_stall),
  .o_device_address(o_device_address), .o_lmp_buffer(o_lmp_buffer),
  .o_lmp_reply_cfg(o_lmp_reply_cfg), .o_lmp_reply_cap(o_lmp_reply_cap), .o_irq(o_irq));
`default_nettype wire

// >>> tb/upe_host_model.sv
// Behavioural host that delivers packet, timer and link packet pulses.
`timescale 1ns/1ns
`default_nettype none
module upe_host_model (
  input  wire logic              i_clk,
  output var  upe_pkg::upe_packet_ev_t o_packet,
  output var  upe_pkg::upe_timer_ev_t  o_timer,
  output var  upe_pkg::upe_lmp_t       o_lmp
);
  import upe_pkg::*;
  initial begin
    o_packet = '0;
    o_timer  = '0;
    o_lmp    = '0;
  end
  task automatic send(input upe_packet_ev_t p, input upe_timer_ev_t t, input upe_lmp_t l);
    o_packet <= p;
    o_timer  <= t;
    o_lmp    <= l;
    @(posedge i_clk);
    o_packet <= '0;
    o_timer  <= '0;
    o_lmp    <= '0;
    #1;
  endtask : send
endmodule : upe_host_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench of the protocol event register.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import upe_pkg::*;
  localparam logic [31:0] CA = PROTOCOL_EVENT_CAUSES_ADDR;
  logic                  i_clk    = 1'b0;
  logic                  i_rst_n  = 1'b0;
  logic [31:0]           i_addr   = 32'h0;
  logic [31:0]           i_wdata  = 32'h0;
  logic                  i_wr     = 1'b0;
  logic                  i_rd     = 1'b0;
  logic                  auto_cfg = 1'b1;
  logic                  auto_cap = 1'b1;
  logic [31:0]           rdata;
  logic                  stall;
  logic [DEV_ADDR_W-1:0] dev_addr;
  logic [LMP_W-1:0]      lmp_buf;
  logic                  rep_cfg;
  logic                  rep_cap;
  logic                  irq;
  upe_packet_ev_t        pkt;
  upe_timer_ev_t         tmr;
  upe_lmp_t              lmp;
  logic [15:0]           en         = 16'h0;
  int                    num_errors = 0;
  int                    compares   = 0;
  always #20 i_clk = ~i_clk;
  upe_host_model u_host (.i_clk(i_clk), .o_packet(pkt), .o_timer(tmr), .o_lmp(lmp));
  upe_protocol_event_register u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_packet(pkt), .i_timer(tmr), .i_lmp(lmp),
    .i_auto_reply_cfg(auto_cfg), .i_auto_reply_cap(auto_cap), .o_ep0_stall(stall),
    .o_device_address(dev_addr), .o_lmp_buffer(lmp_buf), .o_lmp_reply_cfg(rep_cfg),
    .o_lmp_reply_cap(rep_cap), .o_irq(irq));
  task automatic conclude();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask : rd
  function automatic upe_lmp_t lm(input upe_lmp_kind_t k, input logic [6:0] s,
                                  input logic [7:0] h, input logic [1:0] dr);
    lm = '{1'b1, k, s, h, dr, {s, h, 17'h0abcd}};
  endfunction : lm
  task automatic ev(input upe_packet_ev_t p, input upe_timer_ev_t t, input upe_lmp_t l,
                    input logic [15:0] exp, input logic [1:0] rep);
    u_host.send(p, t, l);
    chk({30'h0, rep_cfg, rep_cap}, {30'h0, rep}, "reply");
    if (l.valid) chk(lmp_buf, l.payload, "buffer");
    rd(CA, {16'h0, exp}, "causes");
    chk({31'h0, irq}, {31'h0, |(exp & en)}, "irq");
    wr(CA, 32'h0000ffff);
  endtask : ev
  task automatic set_en(input logic [15:0] v);
    wr(PROTOCOL_EVENT_ENABLES_ADDR, {16'h0, v});
    en = v;
    rd(PROTOCOL_EVENT_ENABLES_ADDR, {16'h0, v}, "enables");
  endtask : set_en
  task automatic t_reset();
    rd(CA, 32'h0, "causes reset");
    rd(PROTOCOL_EVENT_ENABLES_ADDR, 32'h0, "enables reset");
    rd(32'he0033500, 32'h0, "unmapped");
    chk({31'h0, irq}, 32'h0, "irq reset");
  endtask : t_reset
  task automatic t_address();
    set_en(16'hffff);
    ev(upe_packet_ev_t'(17'h1c280), '0, '0, 16'h0000, 2'b00);
    chk({25'h0, dev_addr}, 32'h5, "address");
    ev(upe_packet_ev_t'(17'h1c000), '0, '0, 16'h8000, 2'b00);
    chk({25'h0, dev_addr}, 32'h0, "address zero");
  endtask : t_address
  task automatic t_stall();
    for (int i = 0; i < 3; i++) begin
      ev(upe_packet_ev_t'(17'h10 << i), '0, '0, 16'h4000, 2'b00);
      chk({31'h0, stall}, 32'h1, "stall set");
      rd(PROTOCOL_STATE_ADDR, 32'h80, "state stalled");
      ev(upe_packet_ev_t'(17'h10000), '0, '0, 16'h0200, 2'b00);
      chk({31'h0, stall}, 32'h1, "stall kept");
      ev(upe_packet_ev_t'(17'h18000), '0, '0, 16'h0200, 2'b00);
      chk({31'h0, stall}, 32'h0, "stall left");
      rd(PROTOCOL_STATE_ADDR, 32'h0, "state released");
    end
  endtask : t_stall
  task automatic t_misc();
    ev(upe_packet_ev_t'(17'h08), '0, '0, 16'h0800, 2'b00);
    ev(upe_packet_ev_t'(17'h06), '0, '0, 16'h0400, 2'b00);
    ev(upe_packet_ev_t'(17'h04), '0, '0, 16'h0000, 2'b00);
    ev(upe_packet_ev_t'(17'h01), '0, '0, 16'h0100, 2'b00);
    for (int i = 0; i < 4; i++) begin
      ev('0, upe_timer_ev_t'(4'h8 >> i), '0, 16'h0080 >> i, 2'b00);
    end
  endtask : t_misc
  task automatic t_lmp();
    ev('0, '0, lm(UPE_LMP_PORT_CFG, 7'h02, 8'h04, 2'b01), 16'h2009, 2'b10);
    ev('0, '0, lm(UPE_LMP_PORT_CFG, 7'h01, 8'h04, 2'b01), 16'h0009, 2'b10);
    ev('0, '0, lm(UPE_LMP_PORT_CAP, 7'h01, 8'h04, 2'b01), 16'h0005, 2'b01);
    ev('0, '0, lm(UPE_LMP_PORT_CAP, 7'h00, 8'h04, 2'b01), 16'h1005, 2'b01);
    ev('0, '0, lm(UPE_LMP_PORT_CAP, 7'h01, 8'h03, 2'b01), 16'h1005, 2'b01);
    auto_cap <= 1'b0;
    auto_cfg <= 1'b0;
    ev('0, '0, lm(UPE_LMP_PORT_CAP, 7'h01, 8'h04, 2'b10), 16'h1005, 2'b00);
    ev('0, '0, lm(UPE_LMP_PORT_CFG, 7'h01, 8'h04, 2'b01), 16'h0009, 2'b00);
    auto_cap <= 1'b1;
    auto_cfg <= 1'b1;
    ev('0, '0, lm(UPE_LMP_OTHER, 7'h01, 8'h04, 2'b01), 16'h0003, 2'b00);
    rd(LINK_PACKET_BUFFER_ADDR, 32'h0208abcd, "buffer read");
  endtask : t_lmp
  task automatic t_mask();
    set_en(16'h0001);
    ev('0, upe_timer_ev_t'(4'h4), '0, 16'h0040, 2'b00);
    set_en(16'h0040);
    ev('0, upe_timer_ev_t'(4'h4), '0, 16'h0040, 2'b00);
    set_en(16'h0000);
  endtask : t_mask
  task automatic t_force();
    wr(PROTOCOL_EVENT_FORCE_ADDR, 32'h2);
    rd(PROTOCOL_EVENT_FORCE_ADDR, 32'h0, "force reads");
    wr(CA, 32'h0);
    rd(CA, 32'h2, "forced");
    fork
      u_host.send(upe_packet_ev_t'(17'h01), '0, '0);
      wr(CA, 32'h0102);
    join
    rd(CA, 32'h0100, "set beats clear");
  endtask : t_force
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    t_reset();
    t_address();
    t_stall();
    t_misc();
    t_lmp();
    t_mask();
    t_force();
    conclude();
  end
  initial begin
    #80000;
    num_errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
